// ---- pkg/psg_pkg.sv ----
// Shared types and constants for the parameter access security gate
package psg_pkg;

  // ---------------------------------------------------------------
  // Parameter index layout: menu in the high byte, number in the low
  // ---------------------------------------------------------------
  localparam int unsigned PSG_IDX_W  = 16;
  localparam int unsigned PSG_DATA_W = 12;
  localparam int unsigned PSG_CODE_W = 8;

  // ---------------------------------------------------------------
  // Security code values
  // ---------------------------------------------------------------
  localparam logic [PSG_DATA_W-1:0] PSG_CODE_OFF  = 12'h000;  // Security disabled
  localparam logic [PSG_DATA_W-1:0] PSG_CODE_L1   = 12'h095;  // 149
  localparam logic [PSG_DATA_W-1:0] PSG_CODE_L2   = 12'h0C8;  // 200
  localparam logic [PSG_DATA_W-1:0] PSG_CODE_MAX  = 12'h0FF;  // 255, top of user code range
  localparam logic [PSG_DATA_W-1:0] PSG_SAVE_VAL  = 12'h001;  // Value at xx.00 that asks for a save
  localparam logic [PSG_CODE_W-1:0] PSG_NV_RESET  = 8'h95;    // Working code before the store is loaded
  localparam logic [7:0]            PSG_NUM_ZERO  = 8'h00;    // Index xx.00

  // ---------------------------------------------------------------
  // Special parameter indices
  // ---------------------------------------------------------------
  localparam logic [PSG_IDX_W-1:0] PSG_IDX_SEC      = 16'h0B11;  // 11.17 security code
  localparam logic [PSG_IDX_W-1:0] PSG_IDX_USR_LO   = 16'h0B01;  // 11.01
  localparam logic [PSG_IDX_W-1:0] PSG_IDX_USR_HI   = 16'h0B0A;  // 11.10
  localparam int unsigned          PSG_FREE_COUNT   = 24;

  // Group writable without a code right after power-on, unless a user code is set
  localparam logic [PSG_IDX_W-1:0] PSG_FREE_LIST [0:PSG_FREE_COUNT-1] = '{
    16'h0105, 16'h0106, 16'h0109, 16'h010B, 16'h010C, 16'h010D,
    16'h0204, 16'h0205, 16'h0206, 16'h0207,
    16'h0309, 16'h030A, 16'h030B, 16'h030E, 16'h030F, 16'h0310, 16'h0311,
    16'h0405, 16'h0406, 16'h0505,
    16'h0606, 16'h0607, 16'h0608, 16'h060A
  };

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] menu;
    logic [7:0] num;
    logic       visible;
    logic       read_only;
  } psg_attr_s;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    psg_attr_s             attr;
    logic [PSG_DATA_W-1:0] data;
  } psg_req_s;

  typedef struct packed {
    logic                  mode;
    logic                  reset_key;
    logic                  prog_driven;
    psg_attr_s             attr;
    logic [PSG_DATA_W-1:0] data;
  } psg_key_s;

  typedef struct packed {
    logic valid;
    logic read_ok;
    logic write_ok;
  } psg_ans_s;

  typedef enum logic [1:0] {
    PSG_IDLE       = 2'b00,
    PSG_EDIT_CODE  = 2'b01,
    PSG_EDIT_PARAM = 2'b10
  } psg_edit_e;

endpackage : psg_pkg

// ---- rtl/psg_free_rom.sv ----
// Registered lookup of the power-on free-access parameter group
`timescale 1ns/1ps
module psg_free_rom (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rst_n,
  input  wire logic [psg_pkg::PSG_IDX_W-1:0]  i_idx_a,
  input  wire logic [psg_pkg::PSG_IDX_W-1:0]  i_idx_b,
  output logic                                o_hit_a,
  output logic                                o_hit_b
);

  typedef struct packed {
    logic hit_a;
    logic hit_b;
  } psg_rom_state_s;

  psg_rom_state_s s;
  psg_rom_state_s next_s;

  // ---------------------------------------------------------------
  // Membership test
  // ---------------------------------------------------------------
  function automatic logic is_free(input logic [psg_pkg::PSG_IDX_W-1:0] idx);
    logic hit;
    hit = (idx >= psg_pkg::PSG_IDX_USR_LO) && (idx <= psg_pkg::PSG_IDX_USR_HI);
    for (int i = 0; i < psg_pkg::PSG_FREE_COUNT; i++) begin
      if (idx == psg_pkg::PSG_FREE_LIST[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_free

  // Two lookups so request and keypad paths never contend
  always_comb begin
    next_s       = s;
    next_s.hit_a = is_free(i_idx_a);
    next_s.hit_b = is_free(i_idx_b);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_hit_a = s.hit_a;
  assign o_hit_b = s.hit_b;

endmodule : psg_free_rom

// ---- rtl/psg_gate.sv ----
// Security gate deciding read and write access to drive parameters
`timescale 1ns/1ps
module psg_gate (
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_rst_n,
  input  wire psg_pkg::psg_req_s               i_req,
  input  wire psg_pkg::psg_key_s               i_key,
  input  wire logic [psg_pkg::PSG_CODE_W-1:0]  i_nv_code,
  output psg_pkg::psg_ans_s                    o_ans,
  output logic                                 o_flash,
  output logic                                 o_save,
  output logic [psg_pkg::PSG_CODE_W-1:0]       o_nv_code,
  output logic [psg_pkg::PSG_CODE_W-1:0]       o_code_value
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    psg_pkg::psg_edit_e                 edit;
    logic                               loaded;
    logic                               lvl1;
    logic                               lvl2;
    logic                               lvl3;
    logic                               free_win;
    logic [psg_pkg::PSG_CODE_W-1:0]     nv_code;
    logic [psg_pkg::PSG_CODE_W-1:0]     work_code;
    psg_pkg::psg_req_s                  req_d;
    psg_pkg::psg_key_s                  key_d;
    psg_pkg::psg_ans_s                  ans;
    logic                               flash;
    logic                               save;
  } psg_state_s;

  psg_state_s s;
  psg_state_s next_s;
  logic       hit_req;
  logic       hit_key;

  // ---------------------------------------------------------------
  // Free-group lookup, one cycle, aligned with the delayed events
  // ---------------------------------------------------------------
  psg_free_rom u_free_rom (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_idx_a   ({i_req.attr.menu, i_req.attr.num}),
    .i_idx_b   ({i_key.attr.menu, i_key.attr.num}),
    .o_hit_a   (hit_req),
    .o_hit_b   (hit_key)
  );

  // ---------------------------------------------------------------
  // Access decisions
  // ---------------------------------------------------------------
  // Saved code 0 turns protection off entirely
  function automatic logic sec_off(input psg_state_s st);
    return {4'h0, st.nv_code} == psg_pkg::PSG_CODE_OFF;
  endfunction : sec_off

  // A user code is in force when the saved code is neither 0 nor 149
  function automatic logic l3_set(input psg_state_s st);
    return !sec_off(st) && ({4'h0, st.nv_code} != psg_pkg::PSG_CODE_L1);
  endfunction : l3_set

  function automatic logic rd_ok(input psg_pkg::psg_attr_s a, input psg_state_s st);
    logic ok;
    if (!st.loaded) begin
      ok = 1'b0;
    end else if (sec_off(st)) begin
      ok = 1'b1;
    end else if (l3_set(st) && !st.lvl3) begin
      ok = 1'b0;
    end else if (!a.visible) begin
      ok = st.lvl2;
    end else begin
      ok = 1'b1;
    end
    return ok;
  endfunction : rd_ok

  function automatic logic wr_ok(input psg_pkg::psg_attr_s a, input logic hit, input psg_state_s st);
    logic ok;
    if (!st.loaded || a.read_only) begin
      ok = 1'b0;
    end else if (sec_off(st)) begin
      ok = 1'b1;
    end else if (l3_set(st) && !st.lvl3) begin
      ok = 1'b0;
    end else if (!a.visible) begin
      ok = st.lvl2;
    end else begin
      // Free group only while no user code is set and the window is open
      ok = st.lvl1 || st.lvl2 || (hit && st.free_win && !l3_set(st));
    end
    return ok;
  endfunction : wr_ok

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.req_d     = i_req;
    next_s.key_d     = i_key;
    next_s.ans       = '0;
    next_s.save      = 1'b0;

    // Pull the saved code from the store once after every reset
    if (!s.loaded) begin
      next_s.loaded    = 1'b1;
      next_s.nv_code   = i_nv_code;
      next_s.work_code = i_nv_code;
    end else begin
      // Keypad sequence
      if (s.key_d.mode) begin
        unique case (s.edit)
          psg_pkg::PSG_IDLE: begin
            if (s.key_d.attr.num == psg_pkg::PSG_NUM_ZERO) begin
              next_s.edit = psg_pkg::PSG_EDIT_CODE;
            end else if (wr_ok(s.key_d.attr, hit_key, s) && !s.key_d.prog_driven) begin
              next_s.edit  = psg_pkg::PSG_EDIT_PARAM;
              next_s.flash = 1'b1;
            end else begin
              next_s.flash = 1'b0;
            end
          end
          psg_pkg::PSG_EDIT_CODE: begin
            next_s.edit     = psg_pkg::PSG_IDLE;
            // Any code entry ends the power-on free window
            next_s.free_win = 1'b0;
            if (l3_set(s) && !s.lvl3) begin
              // Only the user code is heard until it has been given
              if (s.key_d.data == {4'h0, s.nv_code}) begin
                next_s.lvl3 = 1'b1;
              end
            end else if (s.key_d.data == psg_pkg::PSG_CODE_L1) begin
              next_s.lvl1 = 1'b1;
            end else if (s.key_d.data == psg_pkg::PSG_CODE_L2) begin
              next_s.lvl2 = 1'b1;
            end
          end
          psg_pkg::PSG_EDIT_PARAM: begin
            next_s.edit  = psg_pkg::PSG_IDLE;
            next_s.flash = 1'b0;
          end
          default: begin
            next_s.edit  = psg_pkg::PSG_IDLE;
            next_s.flash = 1'b0;
          end
        endcase
      end

      // Save action commits the working code to the store
      if (s.key_d.reset_key && (s.key_d.attr.num == psg_pkg::PSG_NUM_ZERO) &&
          (s.key_d.data == psg_pkg::PSG_SAVE_VAL)) begin
        next_s.nv_code = s.work_code;
        next_s.save    = 1'b1;
      end

      // Access request answer
      if (s.req_d.valid) begin
        next_s.ans.valid    = 1'b1;
        next_s.ans.read_ok  = rd_ok(s.req_d.attr, s);
        next_s.ans.write_ok = s.req_d.write && wr_ok(s.req_d.attr, hit_req, s);
        // Writes of 0 to 255 to the code parameter land in the working copy
        if (s.req_d.write && wr_ok(s.req_d.attr, hit_req, s) &&
            ({s.req_d.attr.menu, s.req_d.attr.num} == psg_pkg::PSG_IDX_SEC) &&
            (s.req_d.data <= psg_pkg::PSG_CODE_MAX)) begin
          next_s.work_code = s.req_d.data[psg_pkg::PSG_CODE_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register; reset clears all accepted levels
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s           <= '0;
      s.edit      <= psg_pkg::PSG_IDLE;
      s.lvl1      <= 1'b0;
      s.lvl2      <= 1'b0;
      s.lvl3      <= 1'b0;
      s.free_win  <= 1'b1;
      s.nv_code   <= psg_pkg::PSG_NV_RESET;
      s.work_code <= psg_pkg::PSG_NV_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign o_ans        = s.ans;
  assign o_flash      = s.flash;
  assign o_save       = s.save;
  assign o_nv_code    = s.nv_code;
  assign o_code_value = s.work_code;

endmodule : psg_gate

// ---- test/psg_gate_properties.sv ----
// Port-level assertions for the parameter access security gate
`timescale 1ns/1ps
module psg_gate_properties (
  input wire logic                           i_clk_sys,
  input wire logic                           i_rst_n,
  input wire psg_pkg::psg_req_s              i_req,
  input wire psg_pkg::psg_key_s              i_key,
  input wire logic [psg_pkg::PSG_CODE_W-1:0] i_nv_code,
  input wire psg_pkg::psg_ans_s              o_ans,
  input wire logic                           o_flash,
  input wire logic                           o_save,
  input wire logic [psg_pkg::PSG_CODE_W-1:0] o_nv_code,
  input wire logic [psg_pkg::PSG_CODE_W-1:0] o_code_value
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------
  // Key sequences
  // ----------------------------------------------------------
  sequence s_save_ask;
    i_key.reset_key && i_key.attr.num == psg_pkg::PSG_NUM_ZERO && i_key.data == psg_pkg::PSG_SAVE_VAL;
  endsequence
  // A press that opens a parameter edit (display not yet flashing)
  sequence s_edit_open;
    i_key.mode && i_key.attr.num != psg_pkg::PSG_NUM_ZERO && !o_flash;
  endsequence
  // ----------------------------------------------------------
  // Answers
  // ----------------------------------------------------------
  a_ans_delay: assert property (i_req.valid |-> ##2 o_ans.valid) else $error("answer missing");
  a_ans_cause: assert property (o_ans.valid |-> $past(i_req.valid, 2)) else $error("answer without request");
  a_ro_nowrite: assert property (i_req.valid && i_req.attr.read_only |-> ##2 !o_ans.write_ok)
    else $error("read-only write granted");
  // Save handshake: the stored copy only moves on a save or a reload
  a_save_delay: assert property (s_save_ask |-> ##2 o_save) else $error("save missing");
  a_save_cause: assert property (o_save |-> $past(i_key.reset_key, 2)) else $error("stray save");
  a_save_copy: assert property (o_save |-> o_nv_code == o_code_value) else $error("save copy wrong");
  // The reload lands on the first edge after release, so it shows up two samples after reset
  a_nv_only_save: assert property ($changed(o_nv_code) |-> o_save || !$past(i_rst_n, 2))
    else $error("saved code moved");
  // Display flashing
  a_flash_prog: assert property (s_edit_open ##0 i_key.prog_driven |-> ##2 !o_flash)
    else $error("flash on driven param");
  a_flash_ro: assert property (s_edit_open ##0 i_key.attr.read_only |-> ##2 !o_flash)
    else $error("flash on read-only");
  a_flash_end: assert property (i_key.mode && o_flash |=> o_flash ##1 !o_flash) else $error("flash not ended");
endmodule : psg_gate_properties

bind psg_gate psg_gate_properties u_props (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req),
  .i_key(i_key), .i_nv_code(i_nv_code), .o_ans(o_ans), .o_flash(o_flash), .o_save(o_save),
  .o_nv_code(o_nv_code), .o_code_value(o_code_value));

// ---- test/psg_keypad.sv ----
// Keypad operator model driving mode and reset presses into the gate
`timescale 1ns/1ps
module psg_keypad (
  input  wire logic        i_clk_sys,
  output psg_pkg::psg_key_s o_key
);
  initial o_key = '0;
  // ----------------------------------------------------------
  // Presses
  // ----------------------------------------------------------
  // Key lasts one cycle; two idle cycles follow so the answer lands first
  task automatic press(input logic rk, input logic [15:0] ix, input logic [11:0] d, input logic ro, input logic pd);
    @(posedge i_clk_sys);
    o_key <= '{mode: !rk, reset_key: rk, prog_driven: pd, attr: '{ix[15:8], ix[7:0], 1'b1, ro}, data: d};
    @(posedge i_clk_sys);
    o_key.mode      <= 1'b0;
    o_key.reset_key <= 1'b0;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
  endtask : press
  // Open at index zero, then commit with the code in data
  task automatic enter_code(input logic [11:0] c);
    press(1'b0, 16'h0000, 12'h000, 1'b0, 1'b0);
    press(1'b0, 16'h0000, c, 1'b0, 1'b0);
  endtask : enter_code
  // Value one at xx.00 with the reset key in the same press
  task automatic save;
    press(1'b1, 16'h0000, psg_pkg::PSG_SAVE_VAL, 1'b0, 1'b0);
  endtask : save
endmodule : psg_keypad

// ---- test/psg_gate_bench.sv ----
// Self-checking bench for the parameter access security gate
`timescale 1ns/1ps
module psg_gate_bench;
  logic                           i_clk_sys    = 1'b0;
  logic                           i_rst_n      = 1'b0;
  psg_pkg::psg_req_s              req          = '0;
  psg_pkg::psg_key_s              key;
  logic [psg_pkg::PSG_CODE_W-1:0] nv_store     = 8'h95;
  psg_pkg::psg_ans_s              ans;
  logic                           flash;
  logic                           save;
  logic [psg_pkg::PSG_CODE_W-1:0] nv_code;
  logic [psg_pkg::PSG_CODE_W-1:0] code_value;
  int                             n_mismatch   = 0;
  int                             total_checks = 0;
  int                             cycles       = 0;
  localparam logic [15:0]         SEC          = psg_pkg::PSG_IDX_SEC;

  always #20 i_clk_sys = ~i_clk_sys;
  psg_gate dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req), .i_key(key), .i_nv_code(nv_store),
    .o_ans(ans), .o_flash(flash), .o_save(save), .o_nv_code(nv_code), .o_code_value(code_value));
  psg_keypad kp (.i_clk_sys(i_clk_sys), .o_key(key));

  // Nonvolatile store stand-in; the cycle ceiling cuts a hang short
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (save === 1'b1) nv_store <= nv_code;
    if (cycles == 8000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One request; only the permission bit that belongs to the access is judged
  task automatic rq(input string nm, input logic w, input logic [15:0] ix, input logic e,
                    input logic vis = 1'b1, input logic ro = 1'b0, input logic [11:0] d = 12'h001);
    @(posedge i_clk_sys) req <= '{1'b1, w, '{ix[15:8], ix[7:0], vis, ro}, d};
    @(posedge i_clk_sys) req.valid <= 1'b0;
    // Answer is registered on the edge after the taking edge and stands one cycle only
    @(posedge i_clk_sys);
    #1;
    chk(nm, {10'h000, ans.valid, w ? ans.write_ok : ans.read_ok}, {10'h000, 1'b1, e});
  endtask : rq
  task automatic fl(input string nm, input logic [15:0] ix, input logic ro, input logic pd, input logic e);
    kp.press(1'b0, ix, 12'h000, ro, pd);
    #1;
    chk(nm, {11'h000, flash}, {11'h000, e});
  endtask : fl
  // Power cycle: reset held ten cycles, first request no earlier than edge two
  task automatic restart;
    @(posedge i_clk_sys) i_rst_n <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
  endtask : restart
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_power_on;
    rq("read vis", 1'b0, 16'h0104, 1'b1);
    rq("write prot", 1'b1, 16'h0104, 1'b0);
    rq("write ro", 1'b1, 16'h0101, 1'b0, 1'b1, 1'b1);
    rq("read inv", 1'b0, 16'h0213, 1'b0, 1'b0);
    for (int i = 0; i < psg_pkg::PSG_FREE_COUNT; i++) rq("free", 1'b1, psg_pkg::PSG_FREE_LIST[i], 1'b1);
    for (int k = 1; k <= 10; k++) rq("user menu", 1'b1, {8'h0B, 8'(k)}, 1'b1);
    fl("flash free", 16'h0105, 1'b0, 1'b0, 1'b1);
    fl("flash close", 16'h0105, 1'b0, 1'b0, 1'b0);
    fl("flash prog", 16'h0105, 1'b0, 1'b1, 1'b0);
    fl("steady prot", 16'h0104, 1'b0, 1'b0, 1'b0);
    fl("steady ro", 16'h0101, 1'b1, 1'b0, 1'b0);
    kp.enter_code(12'h07B);
    rq("free closed", 1'b1, 16'h0105, 1'b0);
    kp.enter_code(psg_pkg::PSG_CODE_L1);
    rq("l1 vis", 1'b1, 16'h0104, 1'b1);
    rq("l1 inv", 1'b1, 16'h0213, 1'b0, 1'b0);
    fl("flash l1", 16'h0104, 1'b0, 1'b0, 1'b1);
    fl("flash l1 end", 16'h0104, 1'b0, 1'b0, 1'b0);
    kp.enter_code(psg_pkg::PSG_CODE_L2);
    rq("l2 inv wr", 1'b1, 16'h0213, 1'b1, 1'b0);
    rq("l2 inv ro", 1'b0, 16'h0201, 1'b1, 1'b0, 1'b1);
    $display("test power_on done");
  endtask : t_power_on
  task automatic t_sec_off;
    rq("code zero", 1'b1, SEC, 1'b1, 1'b1, 1'b0, 12'h000);
    chk("work code", {4'h0, code_value}, 12'h000);
    kp.save();
    #1;
    chk("saved code", {4'h0, nv_code}, 12'h000);
    restart();
    chk("kept code", {4'h0, code_value}, 12'h000);
    rq("off inv", 1'b1, 16'h0213, 1'b1, 1'b0);
    rq("code back", 1'b1, SEC, 1'b1, 1'b1, 1'b0, psg_pkg::PSG_CODE_L1);
    kp.save();
    restart();
    rq("prot again", 1'b1, 16'h0104, 1'b0);
    $display("test sec_off done");
  endtask : t_sec_off
  task automatic t_level3;
    kp.enter_code(psg_pkg::PSG_CODE_L2);
    rq("code big", 1'b1, SEC, 1'b1, 1'b1, 1'b0, 12'h100);
    chk("big kept out", {4'h0, code_value}, 12'h095);
    rq("code user", 1'b1, SEC, 1'b1, 1'b1, 1'b0, 12'h05A);
    kp.save();
    restart();
    rq("l3 read", 1'b0, 16'h0101, 1'b0, 1'b1, 1'b1);
    rq("l3 free", 1'b1, 16'h0105, 1'b0);
    kp.enter_code(psg_pkg::PSG_CODE_L1);
    rq("l1 alone", 1'b1, 16'h0104, 1'b0);
    kp.enter_code(12'h05A);
    kp.enter_code(psg_pkg::PSG_CODE_L1);
    rq("l3 l1 wr", 1'b1, 16'h0104, 1'b1);
    rq("l3 l1 inv", 1'b1, 16'h0213, 1'b0, 1'b0);
    restart();
    kp.enter_code(psg_pkg::PSG_CODE_L2);
    rq("l2 first", 1'b1, 16'h0213, 1'b0, 1'b0);
    kp.enter_code(12'h05A);
    kp.enter_code(psg_pkg::PSG_CODE_L2);
    rq("l3 l2 inv", 1'b1, 16'h0213, 1'b1, 1'b0);
    rq("code 149", 1'b1, SEC, 1'b1, 1'b1, 1'b0, psg_pkg::PSG_CODE_L1);
    kp.save();
    restart();
    rq("open read", 1'b0, 16'h0101, 1'b1, 1'b1, 1'b1);
    rq("levels gone", 1'b1, 16'h0104, 1'b0);
    $display("test level3 done");
  endtask : t_level3

  initial begin
    restart();
    t_power_on();
    t_sec_off();
    t_level3();
    wrap_up();
  end
endmodule : psg_gate_bench
